// ---- hw/fcl_cfg.svh ----
/*
 * Constants of the fuse configuration loader: fuse offsets, register map,
 * reset values of the shadow bytes, field codes and timing figures.
 * Assumes it is included by the package and the modules, never compiled alone.
 */
`ifndef FCL_CFG_SVH
`define FCL_CFG_SVH

// fuse byte offsets, also the register addresses of the read-only shadows
`define FCL_OFF_BRN 8'h01
`define FCL_OFF_OSC 8'h02
`define FCL_OFF_SYS0 8'h05
`define FCL_OFF_SYS1 8'h06
`define FCL_OFF_APP 8'h07
`define FCL_OFF_BOOT 8'h08

// extra registers of this block
`define FCL_OFF_STAT 8'h10
`define FCL_OFF_FTRIM 8'h11
`define FCL_OFF_TTRIM 8'h12

// shadow slots, in load order
`define FCL_IX_BRN 3'd0
`define FCL_IX_OSC 3'd1
`define FCL_IX_SYS0 3'd2
`define FCL_IX_SYS1 3'd3
`define FCL_IX_APP 3'd4
`define FCL_IX_BOOT 3'd5
`define FCL_IX_LAST 3'd5
`define FCL_IX_COUNT 6

// shadow reset values
`define FCL_RST_BRN 8'h00
`define FCL_RST_OSC 8'h02
`define FCL_RST_SYS0 8'hc4
`define FCL_RST_SYS1 8'h07
`define FCL_RST_APP 8'h00
`define FCL_RST_BOOT 8'h00

// field codes
`define FCL_MODE_DIS 2'h0
`define FCL_MODE_ON 2'h1
`define FCL_MODE_SAMP 2'h2
`define FCL_MODE_HOLD 2'h3
`define FCL_FREQ_16M 2'h1
`define FCL_FREQ_20M 2'h2
`define FCL_PIN_GPIO 2'h0
`define FCL_PIN_DEBUG 2'h1
`define FCL_PIN_RESET 2'h2
`define FCL_SCAN_FULL 2'h0
`define FCL_SCAN_BOOT 2'h1
`define FCL_SCAN_BOOTCODE 2'h2
`define FCL_SCAN_OFF 2'h3
`define FCL_LIMIT_WHOLE 8'h00

// flash size in 256-byte blocks
`define FCL_FLASH_BLOCKS 9'h040

// timing: clock period and start-up step in ns, blanking in slow-oscillator cycles
`define FCL_CLK_PERIOD_NS 50
`define FCL_DLY_STEP_NS 1000000
`define FCL_PIN_BLANK_TICKS 24'h000300

`endif

// ---- hw/fcl_pkg.sv ----
/*
 * Types of the fuse configuration loader: sequencer states, field layouts
 * of the fuse bytes, carriers toward the peripherals and shared decoders.
 * Assumes fcl_cfg.svh is on the include path.
 */
`include "fcl_cfg.svh"

package fcl_pkg;

    typedef enum logic [4:0] {
        FCL_S_HOLD = 5'b00001,
        FCL_S_READ = 5'b00010,
        FCL_S_CAPT = 5'b00100,
        FCL_S_DLY = 5'b01000,
        FCL_S_RUN = 5'b10000
    } fcl_state_t;

    typedef struct packed {
        logic on;
        logic sampled;
        logic wake_hold;
        logic rsvd;
    } fcl_mode_t;

    typedef struct packed {
        logic [2:0] threshold_level;
        logic sample_rate_select;
        fcl_mode_t active;
        fcl_mode_t sleep;
    } fcl_brn_out_t;

    typedef struct packed {
        logic [7:0] freq16;
        logic [7:0] temp16;
        logic [7:0] freq20;
        logic [7:0] temp20;
    } fcl_factory_trim_t;

    typedef struct packed {
        logic calibration_lock;
        logic run_16m;
        logic run_20m;
        logic freq_rsvd;
        logic [7:0] frequency_trim;
        logic [7:0] temperature_trim;
    } fcl_osc_out_t;

    typedef struct packed {
        logic scan_en;
        logic [1:0] scan_region_select;
        logic [8:0] scan_top;
    } fcl_scan_t;

    typedef struct packed {
        logic gpio;
        logic debug;
        logic ext_reset;
        logic rsvd;
        logic drv_block;
    } fcl_pin_t;

    typedef struct packed {
        fcl_state_t st;
        logic [2:0] idx;
        logic por_pend;
        logic loaded;
        logic [`FCL_IX_COUNT-1:0][7:0] shadow;
        logic [7:0] ftrim;
        logic [7:0] ttrim;
        logic [7:0] rd_data;
        logic erase_flash;
        logic erase_eeprom;
    } fcl_main_t;

    typedef struct packed {
        logic [23:0] cnt;
    } fcl_timer_t;

    // detector mode code to control bits; code 3 means wake-hold awake, reserved asleep
    function automatic fcl_mode_t fcl_mode_dec(input logic [1:0] code, input logic is_sleep);
        fcl_mode_t m;
        m = '0;
        case (code)
            `FCL_MODE_DIS: m = '0;
            `FCL_MODE_ON: m.on = 1'b1;
            `FCL_MODE_SAMP: m.sampled = 1'b1;
            default: begin
                m.on = !is_sleep;
                m.wake_hold = !is_sleep;
                m.rsvd = is_sleep;
            end
        endcase
        return m;
    endfunction

    function automatic logic [7:0] fcl_fuse_off(input logic [2:0] ix);
        case (ix)
            `FCL_IX_BRN: return `FCL_OFF_BRN;
            `FCL_IX_OSC: return `FCL_OFF_OSC;
            `FCL_IX_SYS0: return `FCL_OFF_SYS0;
            `FCL_IX_SYS1: return `FCL_OFF_SYS1;
            `FCL_IX_APP: return `FCL_OFF_APP;
            default: return `FCL_OFF_BOOT;
        endcase
    endfunction

endpackage

// ---- hw/fcl_cycle_timer.sv ----
/*
 * Down counter that stays busy for a loaded number of ticks.
 * Assumes start, clr and tick are synchronous to core_clk; start beats clr.
 */
`timescale 1ns/1ns
`include "fcl_cfg.svh"

module fcl_cycle_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic clr,
    input wire logic tick,
    input wire logic [23:0] load_cnt,
    output logic busy
);
    fcl_pkg::fcl_timer_t r, n;

    always_comb begin
        n = r;
        if (start) begin
            n.cnt = load_cnt;
        end else if (clr) begin
            n.cnt = '0;
        end else if (tick && r.cnt != 24'h000000) begin
            n.cnt = r.cnt - 24'h000001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy = (r.cnt != 24'h000000);
endmodule

// ---- hw/fcl_region_map.sv ----
/*
 * Flash partition and scan range from the two limit bytes and the scan select.
 * Assumes all limits count 256-byte blocks; purely combinational.
 */
`timescale 1ns/1ns
`include "fcl_cfg.svh"

module fcl_region_map (
    input wire logic [7:0] boot_limit,
    input wire logic [7:0] app_limit,
    input wire logic [1:0] scan_sel,
    output logic [8:0] boot_top,
    output logic [8:0] app_top,
    output fcl_pkg::fcl_scan_t scan
);
    always_comb begin
        if (boot_limit == `FCL_LIMIT_WHOLE) begin
            boot_top = `FCL_FLASH_BLOCKS;
            app_top = `FCL_FLASH_BLOCKS;
        end else begin
            boot_top = {1'b0, boot_limit};
            if (app_limit == `FCL_LIMIT_WHOLE) begin
                app_top = `FCL_FLASH_BLOCKS;
            end else if (app_limit < boot_limit) begin
                // a limit below the boot end leaves no code section
                app_top = {1'b0, boot_limit};
            end else begin
                app_top = {1'b0, app_limit};
            end
        end
        // a limit past the end of flash is clipped so nothing maps beyond it
        if (boot_top > `FCL_FLASH_BLOCKS) begin
            boot_top = `FCL_FLASH_BLOCKS;
        end
        if (app_top > `FCL_FLASH_BLOCKS) begin
            app_top = `FCL_FLASH_BLOCKS;
        end
        scan.scan_region_select = scan_sel;
        scan.scan_en = (scan_sel != `FCL_SCAN_OFF);
        case (scan_sel)
            `FCL_SCAN_FULL: scan.scan_top = `FCL_FLASH_BLOCKS;
            `FCL_SCAN_BOOT: scan.scan_top = boot_top;
            `FCL_SCAN_BOOTCODE: scan.scan_top = app_top;
            default: scan.scan_top = 9'h000;
        endcase
    end
endmodule

// ---- hw/fcl_loader.sv ----
/*
 * Fuse configuration loader: after every reset it reads the configuration
 * fuse bytes into shadow storage (the detector byte on power-on only), then hands the decoded settings to the
 * detector, oscillator, scan, pin, erase and flash-partition logic.
 * Assumes a fuse store that answers a read strobe with data one cycle later,
 * rst_n as the power-on reset and sys_rst as every other reset cause,
 * slow_tick as a one-cycle pulse per slow-oscillator cycle.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "fcl_cfg.svh"

module fcl_loader #(
    parameter logic [23:0] MS_CYCLES = 24'(`FCL_DLY_STEP_NS / `FCL_CLK_PERIOD_NS)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sys_rst,
    input wire logic slow_tick,
    output logic fuse_rd,
    output logic [7:0] fuse_addr,
    input wire logic [7:0] fuse_rdata,
    input wire fcl_pkg::fcl_factory_trim_t factory_trim,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic periph_release,
    output logic code_run,
    output fcl_pkg::fcl_brn_out_t brn_cfg,
    output fcl_pkg::fcl_osc_out_t osc_cfg,
    output fcl_pkg::fcl_scan_t scan_cfg,
    output fcl_pkg::fcl_pin_t pin_cfg,
    output logic [8:0] boot_top,
    output logic [8:0] app_top,
    input wire logic chip_erase_req,
    input wire logic device_locked,
    output logic erase_flash,
    output logic erase_eeprom
);
    localparam fcl_pkg::fcl_main_t MAIN_RST = '{
        st: fcl_pkg::FCL_S_READ,
        idx: `FCL_IX_BRN,
        por_pend: 1'b1,
        loaded: 1'b0,
        shadow: {`FCL_RST_BOOT, `FCL_RST_APP, `FCL_RST_SYS1, `FCL_RST_SYS0, `FCL_RST_OSC, `FCL_RST_BRN},
        ftrim: 8'h00,
        ttrim: 8'h00,
        rd_data: 8'h00,
        erase_flash: 1'b0,
        erase_eeprom: 1'b0
    };

    fcl_pkg::fcl_main_t r, n;
    logic start_tmr;
    logic dly_busy;
    logic blank_busy;
    logic [7:0] brn_b, osc_b, sys0_b, sys1_b;
    logic [1:0] pin_code;
    logic [1:0] freq_code;
    logic [7:0] status_b;

    // start-up delay doubles per code step from 1 ms; code zero is no delay
    function automatic logic [23:0] dly_cycles(input logic [2:0] code);
        if (code == 3'h0) begin
            return 24'h000000;
        end
        return MS_CYCLES << (code - 3'h1);
    endfunction

    assign brn_b = r.shadow[`FCL_IX_BRN];
    assign osc_b = r.shadow[`FCL_IX_OSC];
    assign sys0_b = r.shadow[`FCL_IX_SYS0];
    assign sys1_b = r.shadow[`FCL_IX_SYS1];
    assign pin_code = sys0_b[3:2];
    assign freq_code = osc_b[1:0];

    assign status_b = {1'b0, pin_cfg.rsvd, brn_cfg.sleep.rsvd, osc_cfg.freq_rsvd,
                       dly_busy, blank_busy, r.por_pend, r.loaded};

    always_comb begin
        n = r;
        n.rd_data = 8'h00;
        n.erase_flash = 1'b0;
        n.erase_eeprom = 1'b0;
        start_tmr = 1'b0;

        case (r.st)
            fcl_pkg::FCL_S_HOLD: begin
                n.idx = `FCL_IX_BRN;
                n.st = fcl_pkg::FCL_S_READ;
            end
            fcl_pkg::FCL_S_READ: begin
                n.st = fcl_pkg::FCL_S_CAPT;
            end
            fcl_pkg::FCL_S_CAPT: begin
                // the detector byte is only taken on the power-on pass
                if (r.idx != `FCL_IX_BRN || r.por_pend) begin
                    n.shadow[r.idx] = fuse_rdata;
                end
                if (r.idx == `FCL_IX_OSC) begin
                    case (fuse_rdata[1:0])
                        `FCL_FREQ_16M: begin
                            n.ftrim = factory_trim.freq16;
                            n.ttrim = factory_trim.temp16;
                        end
                        `FCL_FREQ_20M: begin
                            n.ftrim = factory_trim.freq20;
                            n.ttrim = factory_trim.temp20;
                        end
                        default: begin
                            // reserved code: trims keep their last value
                            n.ftrim = r.ftrim;
                        end
                    endcase
                end
                if (r.idx == `FCL_IX_LAST) begin
                    n.loaded = 1'b1;
                    start_tmr = 1'b1;
                    n.por_pend = 1'b0;
                    // start-up delay applies to power-on only
                    n.st = r.por_pend ? fcl_pkg::FCL_S_DLY : fcl_pkg::FCL_S_RUN;
                end else begin
                    n.idx = r.idx + 3'd1;
                    n.st = fcl_pkg::FCL_S_READ;
                end
            end
            fcl_pkg::FCL_S_DLY: begin
                if (!dly_busy) begin
                    n.st = fcl_pkg::FCL_S_RUN;
                end
            end
            fcl_pkg::FCL_S_RUN: begin
                n.st = fcl_pkg::FCL_S_RUN;
            end
            default: begin
                n.st = fcl_pkg::FCL_S_HOLD;
            end
        endcase

        // any other reset cause parks the sequencer; the detector shadow is untouched
        if (sys_rst) begin
            n.st = fcl_pkg::FCL_S_HOLD;
            n.idx = `FCL_IX_BRN;
            n.loaded = 1'b0;
        end

        // trims are writable by software only while the lock fuse is clear
        if (reg_wr && r.loaded && !osc_b[7] && r.st == fcl_pkg::FCL_S_RUN) begin
            if (reg_addr == `FCL_OFF_FTRIM) begin
                n.ftrim = reg_wdata;
            end
            if (reg_addr == `FCL_OFF_TTRIM) begin
                n.ttrim = reg_wdata;
            end
        end

        // fuse shadows ignore writes; unmapped addresses read zero
        if (reg_rd) begin
            for (int i = 0; i < `FCL_IX_COUNT; i++) begin
                if (reg_addr == fcl_pkg::fcl_fuse_off(3'(i))) begin
                    n.rd_data = r.shadow[i];
                end
            end
            case (reg_addr)
                `FCL_OFF_STAT: n.rd_data = status_b;
                `FCL_OFF_FTRIM: n.rd_data = r.ftrim;
                `FCL_OFF_TTRIM: n.rd_data = r.ttrim;
                default: n.rd_data = n.rd_data;
            endcase
        end

        // erase requests before the fuses are known are dropped
        if (chip_erase_req && r.loaded) begin
            n.erase_flash = 1'b1;
            n.erase_eeprom = !sys0_b[0] || device_locked;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= MAIN_RST;
        end else begin
            r <= n;
        end
    end

    fcl_cycle_timer u_dly_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(start_tmr && r.por_pend),
        .clr(sys_rst),
        .tick(1'b1),
        .load_cnt(dly_cycles(sys1_b[2:0])),
        .busy(dly_busy)
    );

    // pin driver blanking restarts on every completed load that leaves the pin in GPIO mode
    fcl_cycle_timer u_blank_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(start_tmr && pin_code == `FCL_PIN_GPIO),
        .clr(sys_rst),
        .tick(slow_tick),
        .load_cnt(`FCL_PIN_BLANK_TICKS),
        .busy(blank_busy)
    );

    fcl_region_map u_region_map (
        .boot_limit(r.shadow[`FCL_IX_BOOT]),
        .app_limit(r.shadow[`FCL_IX_APP]),
        .scan_sel(sys0_b[7:6]),
        .boot_top(boot_top),
        .app_top(app_top),
        .scan(scan_cfg)
    );

    assign fuse_rd = (r.st == fcl_pkg::FCL_S_READ);
    assign fuse_addr = fcl_pkg::fcl_fuse_off(r.idx);
    assign reg_rdata = r.rd_data;
    assign periph_release = r.loaded;
    assign code_run = r.loaded && (r.st == fcl_pkg::FCL_S_RUN);
    assign erase_flash = r.erase_flash;
    assign erase_eeprom = r.erase_eeprom;

    assign brn_cfg.threshold_level = brn_b[7:5];
    assign brn_cfg.sample_rate_select = brn_b[4];
    assign brn_cfg.active = fcl_pkg::fcl_mode_dec(brn_b[3:2], 1'b0);
    assign brn_cfg.sleep = fcl_pkg::fcl_mode_dec(brn_b[1:0], 1'b1);

    assign osc_cfg.calibration_lock = osc_b[7];
    assign osc_cfg.run_16m = (freq_code == `FCL_FREQ_16M);
    assign osc_cfg.run_20m = (freq_code == `FCL_FREQ_20M);
    assign osc_cfg.freq_rsvd = !osc_cfg.run_16m && !osc_cfg.run_20m;
    assign osc_cfg.frequency_trim = r.ftrim;
    assign osc_cfg.temperature_trim = r.ttrim;

    assign pin_cfg.gpio = (pin_code == `FCL_PIN_GPIO);
    assign pin_cfg.debug = (pin_code == `FCL_PIN_DEBUG);
    assign pin_cfg.ext_reset = (pin_code == `FCL_PIN_RESET);
    assign pin_cfg.rsvd = !pin_cfg.gpio && !pin_cfg.debug && !pin_cfg.ext_reset;
    // driver held off until loaded and through blanking, avoiding a clash with a high-voltage entry
    assign pin_cfg.drv_block = pin_cfg.gpio && (!r.loaded || blank_busy);
endmodule

// ---- bench/fcl_loader_properties.sv ----
/*
 * Checker for the fuse configuration loader: timing relations between its ports.
 * Assumes it is bound to fcl_loader and that the design has one clock domain.
 */
`timescale 1ns/1ns
module fcl_loader_properties #(
    parameter logic [23:0] MS_CYCLES = 24'h004e20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sys_rst,
    input wire logic slow_tick,
    input wire logic fuse_rd,
    input wire logic [7:0] fuse_addr,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic periph_release,
    input wire logic code_run,
    input wire fcl_pkg::fcl_brn_out_t brn_cfg,
    input wire fcl_pkg::fcl_osc_out_t osc_cfg,
    input wire fcl_pkg::fcl_pin_t pin_cfg,
    input wire logic chip_erase_req,
    input wire logic device_locked,
    input wire logic erase_flash,
    input wire logic erase_eeprom
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic [9:0] tick_cnt_r;
    // slow ticks since release; saturates so a long run never wraps into the blank window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            tick_cnt_r <= 10'h000;
        else if (!periph_release)
            tick_cnt_r <= 10'h000;
        else if (slow_tick && tick_cnt_r != 10'h3ff)
            tick_cnt_r <= tick_cnt_r + 10'h001;
    end
    property p_fuse_seq;
        disable iff (!rst_n || sys_rst) fuse_rd && fuse_addr == 8'h01 |=> !fuse_rd ##1 fuse_rd && fuse_addr == 8'h02;
    endproperty
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_rd_brn;
        reg_rd && reg_addr == 8'h01 && periph_release |=>
            reg_rdata[7:5] == brn_cfg.threshold_level && reg_rdata[4] == brn_cfg.sample_rate_select;
    endproperty
    property p_rd_lock;
        reg_rd && reg_addr == 8'h02 && periph_release |=> reg_rdata[7] == osc_cfg.calibration_lock;
    endproperty
    property p_erase_locked;
        chip_erase_req && periph_release && device_locked |=> erase_flash && erase_eeprom;
    endproperty
    property p_erase_drop;
        !(chip_erase_req && periph_release) |=> !erase_flash && !erase_eeprom;
    endproperty
    property p_blank_pre;
        pin_cfg.gpio && !periph_release |-> pin_cfg.drv_block;
    endproperty
    property p_blank_hold;
        pin_cfg.gpio && periph_release && tick_cnt_r < 10'd767 |-> pin_cfg.drv_block;
    endproperty
    property p_blank_end;
        pin_cfg.gpio && tick_cnt_r > 10'd769 |-> !pin_cfg.drv_block;
    endproperty
    property p_run;
        code_run |-> periph_release;
    endproperty
    a_fuse_seq: assert property (p_fuse_seq) else $error("fuse reads out of order");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_rd_brn: assert property (p_rd_brn) else $error("detector level or rate differs from shadow");
    a_rd_lock: assert property (p_rd_lock) else $error("lock differs from shadow");
    a_erase_locked: assert property (p_erase_locked) else $error("locked erase kept eeprom");
    a_erase_drop: assert property (p_erase_drop) else $error("erase pulse without request");
    a_blank_pre: assert property (p_blank_pre) else $error("pin driver on before load");
    a_blank_hold: assert property (p_blank_hold) else $error("pin driver on too early");
    a_blank_end: assert property (p_blank_end) else $error("pin driver still blocked");
    a_run: assert property (p_run) else $error("code runs before load");
    c_locked: cover property (chip_erase_req && periph_release && device_locked);
    c_blank: cover property ($fell(pin_cfg.drv_block));
    c_run: cover property ($rose(code_run));
endmodule

bind fcl_loader fcl_loader_properties #(.MS_CYCLES(MS_CYCLES)) fcl_loader_properties_i (.core_clk, .rst_n,
    .sys_rst, .slow_tick, .fuse_rd, .fuse_addr, .reg_addr, .reg_rd, .reg_rdata, .periph_release,
    .code_run, .brn_cfg, .osc_cfg, .pin_cfg, .chip_erase_req, .device_locked, .erase_flash, .erase_eeprom);

// ---- bench/fcl_fuse_model.sv ----
/*
 * Fuse store model: answers a read strobe with the byte one cycle later.
 * Assumes fuse_img is ordered brn, osc, sys0, sys1, app, boot.
 */
`timescale 1ns/1ns
module fcl_fuse_model (
    input wire logic core_clk,
    input wire logic fuse_rd,
    input wire logic [7:0] fuse_addr,
    input wire logic [5:0][7:0] fuse_img,
    output logic [7:0] fuse_rdata
);
    initial fuse_rdata = 8'h5a;
    // outside the answer cycle the bus toggles, so a late capture shows up
    always @(posedge core_clk) begin
        case (fuse_rd ? fuse_addr : 8'hff)
            8'h01: fuse_rdata <= fuse_img[0];
            8'h02: fuse_rdata <= fuse_img[1];
            8'h05: fuse_rdata <= fuse_img[2];
            8'h06: fuse_rdata <= fuse_img[3];
            8'h07: fuse_rdata <= fuse_img[4];
            8'h08: fuse_rdata <= fuse_img[5];
            default: fuse_rdata <= ~fuse_rdata;
        endcase
    end
endmodule

// ---- bench/test_fcl_loader.sv ----
/*
 * Testbench of the fuse configuration loader: power-on and other resets,
 * decoded settings, shadow reads, trims, erase and pin blanking.
 * Assumes fcl_fuse_model and the bound checker are compiled before it.
 */
`timescale 1ns/1ns
module test_fcl_loader;
    logic core_clk = 1'b0, rst_n = 1'b0, sys_rst = 1'b0, slow_tick = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, chip_erase_req = 1'b0, device_locked = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fuse_rdata, fuse_addr;
    logic fuse_rd, periph_release, code_run, erase_flash, erase_eeprom, rd_d = 1'b0, er_d = 1'b0;
    logic [8:0] boot_top, app_top, bt, at;
    fcl_pkg::fcl_factory_trim_t factory_trim = '0;
    fcl_pkg::fcl_brn_out_t brn_cfg;
    fcl_pkg::fcl_osc_out_t osc_cfg;
    fcl_pkg::fcl_scan_t scan_cfg;
    fcl_pkg::fcl_pin_t pin_cfg;
    logic [5:0][7:0] img = '0, im;
    logic [7:0] brn_now, tf, tt, x, b8;
    logic [2:0] s;
    logic [7:0] exp_rd[$];
    logic [1:0] exp_er[$];
    integer seed = 32'hd8fe9bff, err_count = 0, checks = 0, cyc = 0, n, k, i, sc, t0;
    localparam logic [5:0][7:0] OFFS = {8'h08, 8'h07, 8'h06, 8'h05, 8'h02, 8'h01};

    fcl_loader #(.MS_CYCLES(24'h000004)) fcl_loader_i (.core_clk(core_clk), .rst_n(rst_n),
        .sys_rst(sys_rst), .slow_tick(slow_tick), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
        .fuse_rdata(fuse_rdata), .factory_trim(factory_trim), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_release(periph_release),
        .code_run(code_run), .brn_cfg(brn_cfg), .osc_cfg(osc_cfg), .scan_cfg(scan_cfg), .pin_cfg(pin_cfg),
        .boot_top(boot_top), .app_top(app_top), .chip_erase_req(chip_erase_req),
        .device_locked(device_locked), .erase_flash(erase_flash), .erase_eeprom(erase_eeprom));
    fcl_fuse_model fcl_fuse_model_i (.core_clk(core_clk), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
        .fuse_img(img), .fuse_rdata(fuse_rdata));

    always #25 core_clk = ~core_clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        slow_tick <= (cyc % 8 == 7);
        if (cyc == 30000) begin
            err_count = err_count + 1;
            close_out;
        end
    end

    // scoreboard: answers come one cycle after the strobe
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        er_d <= chip_erase_req;
        if (rd_d)
            chk(reg_rdata, exp_rd.pop_front());
        if (er_d)
            chk({erase_flash, erase_eeprom}, exp_er.pop_front());
    end

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task er(input logic lk, input logic [1:0] e);
        exp_er.push_back(e);
        device_locked <= lk;
        chip_erase_req <= 1'b1;
        @(posedge core_clk);
        chip_erase_req <= 1'b0;
        @(posedge core_clk);
    endtask

    function logic [3:0] mode_x(input logic [1:0] c, input logic slp);
        case (c)
            2'h0: return 4'h0;
            2'h1: return 4'h8;
            2'h2: return 4'h4;
            default: return slp ? 4'h1 : 4'ha;
        endcase
    endfunction

    function logic [8:0] clip(input logic [7:0] v);
        return (v > 8'h40) ? 9'h040 : {1'b0, v};
    endfunction

    task boot_up(input logic por);
        img <= im;
        if (por)
            rst_n <= 1'b0;
        else
            sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        sys_rst <= 1'b0;
        if (por) begin
            brn_now = im[0];
            tf = 8'h00;
            tt = 8'h00;
        end
        while (periph_release !== 1'b1) @(posedge core_clk);
        t0 = cyc;
        n = 0;
        while (code_run !== 1'b1) begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (im[1][1:0] == 2'h1)
            {tf, tt} = {factory_trim.freq16, factory_trim.temp16};
        if (im[1][1:0] == 2'h2)
            {tf, tt} = {factory_trim.freq20, factory_trim.temp20};
    endtask

    task chk_cfg;
        bt = (img[5] == 8'h00) ? 9'h040 : clip(img[5]);
        at = (img[5] == 8'h00 || img[4] == 8'h00) ? 9'h040 : clip((img[4] < img[5]) ? img[5] : img[4]);
        chk(brn_cfg.threshold_level, brn_now[7:5]);
        chk(brn_cfg.sample_rate_select, brn_now[4]);
        chk(brn_cfg.active, mode_x(brn_now[3:2], 1'b0));
        chk(brn_cfg.sleep, mode_x(brn_now[1:0], 1'b1));
        chk(osc_cfg[19:16], {img[1][7], img[1][1:0] == 2'h1, img[1][1:0] == 2'h2, img[1][1] == img[1][0]});
        chk({osc_cfg.frequency_trim, osc_cfg.temperature_trim}, {tf, tt});
        chk(scan_cfg[11:9], {img[2][7:6] != 2'h3, img[2][7:6]});
        chk(scan_cfg.scan_top, img[2][7] ? (img[2][6] ? 9'h000 : at) : (img[2][6] ? bt : 9'h040));
        chk(pin_cfg[4:1], {img[2][3:2] == 2'h0, img[2][3:2] == 2'h1, img[2][3:2] == 2'h2, img[2][3:2] == 2'h3});
        chk(boot_top, bt);
        chk(app_top, at);
        for (i = 0; i < 6; i = i + 1) begin
            wr(OFFS[i], 8'hff ^ img[i]);
            rd(OFFS[i], (i == 0) ? brn_now : img[i]);
        end
        rd(8'h20, 8'h00);
    endtask

    task one_pass(input logic por);
        s = 3'(k * 5 % 8);
        b8 = 8'h10 * k[1:0];
        im[0] = {(k == 1) ? 3'h2 : (k == 2) ? 3'h7 : 3'h0, k[0], k[1:0], k[1:0]};
        if (!por)
            im[0] = ~im[0];
        im[1] = {k[1], 5'h00, k[1:0]};
        im[2] = {k[1:0], 2'h0, k[1:0], 1'b0, k[0]};
        im[3] = {5'h00, s};
        im[5] = b8;
        // programmer side: app limit is boot size plus code size
        im[4] = (k == 1) ? 8'h00 : b8 + 8'($random(seed) & 8'h3f);
        boot_up(por);
        sc = (s == 3'h0) ? 0 : 4 << (s - 1);
        chk(por ? (n >= sc && n <= sc + 3) : (n <= 2), 1);
        x = $random(seed);
        wr(8'h11, x);
        if (!img[1][7])
            tf = x;
        rd(8'h11, tf);
        chk_cfg;
        er(k[1], {1'b1, ~img[2][0] | k[1]});
        $display("pass %0d por %0d done", k, por);
    endtask

    initial begin
        factory_trim = $random(seed);
        for (k = 0; k < 4; k = k + 1) begin
            one_pass(1'b1);
            if (k == 0) begin
                n = (cyc - t0) / 8;
                // firmware side: pin interrupts stay off until this blank has run out
                while (pin_cfg.drv_block === 1'b1) begin
                    @(posedge core_clk);
                    if (slow_tick)
                        n = n + 1;
                end
                chk(n >= 766 && n <= 769, 1);
                $display("pin blank done");
            end
        end
        sys_rst <= 1'b1;
        @(posedge core_clk);
        er(1'b0, 2'b00);
        for (k = 0; k < 4; k = k + 1)
            one_pass(1'b0);
        close_out;
    end
endmodule
